/* usp_cfg.svh */
// register offsets, field positions, reset values and counts of the serial port control block
`ifndef USP_CFG_SVH
`define USP_CFG_SVH
`define USP_CTL_ADDR 8'h98
`define USP_BUF_ADDR 8'h99
`define USP_BITADDR_HI 5'h13
`define USP_CTL_RESET 8'h40
`define USP_BIT_FRAME 7
`define USP_BIT_RSV 6
`define USP_BIT_MDCHK 5
`define USP_BIT_REN 4
`define USP_BIT_TXNINTH 3
`define USP_BIT_RXNINTH 2
`define USP_BIT_TXDONE 1
`define USP_BIT_RXDONE 0
`define USP_DATA_BITS 4'h8
`define USP_FIFO_WIDTH 8
`define USP_FIFO_DEPTH 8
`define USP_FIFO_AW 3
`endif

/* usp_pkg.sv */
// types shared by the serial port control block
package usp_pkg;
	typedef enum logic [4:0]
	{
		TX_IDLE = 5'h01,
		TX_WAIT = 5'h02,
		TX_DATA = 5'h04,
		TX_NINTH = 5'h08,
		TX_STOP = 5'h10
	} usp_tx_t;
	typedef enum logic [3:0]
	{
		RX_IDLE = 4'h1,
		RX_DATA = 4'h2,
		RX_NINTH = 4'h4,
		RX_STOP = 4'h8
	} usp_rx_t;
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} usp_sfr_req_t;
	typedef struct packed
	{
		logic [7:0] bitAddr;
		logic bitVal;
		logic bitWe;
	} usp_bit_req_t;
	typedef struct packed
	{
		usp_tx_t txState;
		logic [7:0] txShift;
		logic [3:0] txCnt;
		logic txd;
		usp_rx_t rxState;
		logic [7:0] rxShift;
		logic [3:0] rxCnt;
		logic rxNinth;
		logic [7:0] rxLatch;
		logic [7:0] ctl;
		logic [7:0] rdData;
		logic irq;
	} usp_state_t;
endpackage

/* usp_ctrl.sv */
// serial port control: special-function registers, frame engines and transmit fifo
`timescale 1ns/1ns
`include "usp_cfg.svh"

// ****************************************
// transmit fifo
// ****************************************
module usp_fifo #(
	parameter int WIDTH = `USP_FIFO_WIDTH,
	parameter int DEPTH = `USP_FIFO_DEPTH,
	parameter int AW = `USP_FIFO_AW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic full;
		logic empty;
	} usp_fifo_t;
	usp_fifo_t f_r;
	usp_fifo_t f_nxt;
	logic push;
	logic pop;
	assign push = inValid && !f_r.full;
	assign pop = outReady && !f_r.empty;
	assign inReady = !f_r.full;
	assign outValid = !f_r.empty;
	assign outData = f_r.mem[f_r.rp];
	always_comb
	begin
		f_nxt = f_r;
		if (push)
		begin
			f_nxt.mem[f_r.wp] = inData;
			f_nxt.wp = f_r.wp + 1'b1;
		end
		if (pop)
			f_nxt.rp = f_r.rp + 1'b1;
		if (push && !pop)
			f_nxt.cnt = f_r.cnt + 1'b1;
		else if (pop && !push)
			f_nxt.cnt = f_r.cnt - 1'b1;
		f_nxt.full = f_nxt.cnt == (AW+1)'(DEPTH);
		f_nxt.empty = f_nxt.cnt == '0;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			f_r <= '0;
			f_r.empty <= 1'b1;
		end
		else
			f_r <= f_nxt;
	end
endmodule

// ****************************************
// control and frame engines
// ****************************************
module usp_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire usp_pkg::usp_sfr_req_t sfrReq,
	input wire usp_pkg::usp_bit_req_t bitReq,
	output logic [7:0] sfrRdData,
	input wire logic bitTick,
	input wire logic rxd,
	output logic txd,
	output logic irqReq,
	output logic txFifoReady
);
	usp_pkg::usp_state_t s_r;
	usp_pkg::usp_state_t s_nxt;
	logic ctlWr;
	logic bitWr;
	logic bufWr;
	logic [7:0] fifoData;
	logic fifoValid;
	logic fifoPop;
	logic mode9;
	logic stopSample;
	logic rxNinthVal;
	logic rxAccept;
	logic tiSet;
	logic riSet;

	assign ctlWr = sfrReq.we && sfrReq.addr == `USP_CTL_ADDR;
	assign bitWr = bitReq.bitWe && bitReq.bitAddr[7:3] == `USP_BITADDR_HI;
	assign bufWr = sfrReq.we && sfrReq.addr == `USP_BUF_ADDR;
	assign mode9 = s_r.ctl[`USP_BIT_FRAME];
	assign stopSample = bitTick && s_r.rxState == usp_pkg::RX_STOP;
	assign rxNinthVal = mode9 ? s_r.rxNinth : rxd;
	// multidrop check on stop bit or ninth bit, and no overwrite of a pending byte
	assign rxAccept = stopSample && !s_r.ctl[`USP_BIT_RXDONE] && (!s_r.ctl[`USP_BIT_MDCHK] || rxNinthVal);
	assign tiSet = bitTick && ((s_r.txState == usp_pkg::TX_DATA && s_r.txCnt == `USP_DATA_BITS && !mode9)
		|| s_r.txState == usp_pkg::TX_NINTH);
	assign riSet = rxAccept;
	assign fifoPop = s_r.txState == usp_pkg::TX_IDLE && fifoValid;

	// buffer writes while full are dropped; txFifoReady tells software to wait
	usp_fifo #(
		.WIDTH(`USP_FIFO_WIDTH),
		.DEPTH(`USP_FIFO_DEPTH),
		.AW(`USP_FIFO_AW)
	) txFifo (
		.clk(clk),
		.rst_n(rst_n),
		.inData(sfrReq.wdata),
		.inValid(bufWr),
		.inReady(txFifoReady),
		.outData(fifoData),
		.outValid(fifoValid),
		.outReady(fifoPop)
	);

	always_comb
	begin
		s_nxt = s_r;
		// register writes, byte then bit access
		if (ctlWr)
			s_nxt.ctl = sfrReq.wdata;
		if (bitWr)
			s_nxt.ctl[bitReq.bitAddr[2:0]] = bitReq.bitVal;
		s_nxt.ctl[`USP_BIT_RSV] = 1'b1;
		// hardware set applied last so it beats a same-cycle clear
		if (tiSet)
			s_nxt.ctl[`USP_BIT_TXDONE] = 1'b1;
		if (riSet)
		begin
			s_nxt.ctl[`USP_BIT_RXDONE] = 1'b1;
			s_nxt.ctl[`USP_BIT_RXNINTH] = rxNinthVal;
			s_nxt.rxLatch = s_r.rxShift;
		end
		s_nxt.irq = s_nxt.ctl[`USP_BIT_TXDONE] || s_nxt.ctl[`USP_BIT_RXDONE];
		// transmit engine, line changes on bit ticks
		case (s_r.txState)
			usp_pkg::TX_IDLE:
				if (fifoValid)
				begin
					s_nxt.txShift = fifoData;
					s_nxt.txState = usp_pkg::TX_WAIT;
				end
			usp_pkg::TX_WAIT:
				if (bitTick)
				begin
					s_nxt.txd = 1'b0;
					s_nxt.txCnt = '0;
					s_nxt.txState = usp_pkg::TX_DATA;
				end
			usp_pkg::TX_DATA:
				if (bitTick)
				begin
					if (s_r.txCnt == `USP_DATA_BITS)
					begin
						s_nxt.txd = mode9 ? s_r.ctl[`USP_BIT_TXNINTH] : 1'b1;
						s_nxt.txState = mode9 ? usp_pkg::TX_NINTH : usp_pkg::TX_STOP;
					end
					else
					begin
						s_nxt.txd = s_r.txShift[0];
						s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
						s_nxt.txCnt = s_r.txCnt + 4'h1;
					end
				end
			usp_pkg::TX_NINTH:
				if (bitTick)
				begin
					s_nxt.txd = 1'b1;
					s_nxt.txState = usp_pkg::TX_STOP;
				end
			usp_pkg::TX_STOP:
				if (bitTick)
					s_nxt.txState = usp_pkg::TX_IDLE;
			default:
				s_nxt.txState = usp_pkg::TX_IDLE;
		endcase
		// receive engine, one sample per bit tick
		case (s_r.rxState)
			usp_pkg::RX_IDLE:
				if (bitTick && !rxd && s_r.ctl[`USP_BIT_REN])
				begin
					s_nxt.rxCnt = '0;
					s_nxt.rxState = usp_pkg::RX_DATA;
				end
			usp_pkg::RX_DATA:
				if (bitTick)
				begin
					s_nxt.rxShift = {rxd, s_r.rxShift[7:1]};
					s_nxt.rxCnt = s_r.rxCnt + 4'h1;
					if (s_r.rxCnt == `USP_DATA_BITS - 4'h1)
						s_nxt.rxState = mode9 ? usp_pkg::RX_NINTH : usp_pkg::RX_STOP;
				end
			usp_pkg::RX_NINTH:
				if (bitTick)
				begin
					s_nxt.rxNinth = rxd;
					s_nxt.rxState = usp_pkg::RX_STOP;
				end
			usp_pkg::RX_STOP:
				if (bitTick)
					s_nxt.rxState = usp_pkg::RX_IDLE;
			default:
				s_nxt.rxState = usp_pkg::RX_IDLE;
		endcase
		// read data registered; unmapped addresses read zero
		if (sfrReq.re && sfrReq.addr == `USP_CTL_ADDR)
			s_nxt.rdData = s_r.ctl;
		else if (sfrReq.re && sfrReq.addr == `USP_BUF_ADDR)
			s_nxt.rdData = s_r.rxLatch;
		else
			s_nxt.rdData = 8'h00;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			s_r.txState <= usp_pkg::TX_IDLE;
			s_r.rxState <= usp_pkg::RX_IDLE;
			s_r.txd <= 1'b1;
			s_r.ctl <= `USP_CTL_RESET;
		end
		else
			s_r <= s_nxt;
	end

	assign sfrRdData = s_r.rdData;
	assign txd = s_r.txd;
	assign irqReq = s_r.irq;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	reserved_bit_a: assert property (s_r.ctl[`USP_BIT_RSV])
		else $error("reserved control bit not 1");
	stop8_mdchk_a: assert property (stopSample && !mode9 && s_r.ctl[`USP_BIT_MDCHK] && !rxd
		|=> $stable(s_r.ctl[`USP_BIT_RXDONE]) && $stable(s_r.rxLatch))
		else $error("8-bit multidrop accepted a zero stop bit");
	ninth_mdchk_a: assert property (stopSample && mode9 && s_r.ctl[`USP_BIT_MDCHK] && !s_r.rxNinth
		|=> $stable(s_r.ctl[`USP_BIT_RXDONE]))
		else $error("9-bit multidrop accepted a zero ninth bit");
	no_mdchk_a: assert property (stopSample && !s_r.ctl[`USP_BIT_MDCHK] && !s_r.ctl[`USP_BIT_RXDONE]
		|=> s_r.ctl[`USP_BIT_RXDONE] && irqReq)
		else $error("byte not accepted without multidrop check");
	ninth_tx_a: assert property ($rose(s_r.txState == usp_pkg::TX_NINTH) |-> txd == $past(s_r.ctl[`USP_BIT_TXNINTH]))
		else $error("ninth transmit bit wrong");
	rx9_load_a: assert property (rxAccept |=> s_r.ctl[`USP_BIT_RXNINTH] == $past(rxNinthVal))
		else $error("received ninth-bit field wrong");
	txdone_stop_a: assert property ($rose(s_r.txState == usp_pkg::TX_STOP) |-> s_r.ctl[`USP_BIT_TXDONE] && txd)
		else $error("transmit-done not set at stop bit");
	overrun_hold_a: assert property (stopSample && s_r.ctl[`USP_BIT_RXDONE] |=> $stable(s_r.rxLatch))
		else $error("pending byte overwritten");
	ren_gate_a: assert property (!s_r.ctl[`USP_BIT_REN] && s_r.rxState == usp_pkg::RX_IDLE
		|=> s_r.rxState == usp_pkg::RX_IDLE)
		else $error("reception started while disabled");
	set_wins_a: assert property (riSet && ctlWr && !sfrReq.wdata[`USP_BIT_RXDONE] |=> s_r.ctl[`USP_BIT_RXDONE])
		else $error("software clear beat hardware set");
	tx_start_a: assert property (bufWr && txFifoReady && s_r.txState == usp_pkg::TX_IDLE && !fifoValid
		|-> ##2 s_r.txState == usp_pkg::TX_WAIT)
		else $error("buffer write did not start transmission");

	frame8_c: cover property (!mode9 && $rose(s_r.txState == usp_pkg::TX_STOP));
	frame9_c: cover property (mode9 && rxAccept);
	overrun_c: cover property (stopSample && s_r.ctl[`USP_BIT_RXDONE]);
	fifo_full_c: cover property (!txFifoReady);
endmodule

/* usp_remote.sv */
// model of the remote serial transceiver on the far side of the line
`timescale 1ns/1ns
module usp_remote (
	input wire logic clk,
	input wire logic bitTick,
	input wire logic nine,
	input wire logic txd,
	output logic rxd
);
	logic [8:0] q[$];
	logic [8:0] sh;
	int n = 0;
	initial rxd = 1'b1;
	// ****
	// receiver: one sample per tick, sees the bit launched at the previous tick
	// ****
	always @(posedge clk)
	begin
		if (bitTick)
		begin
			if (n == 0 && txd == 1'b0)
				n <= 1;
			else if (n == (nine ? 10 : 9))
			begin
				q.push_back({nine ? sh[8] : txd, sh[7:0]});
				n <= 0;
			end
			else if (n > 0)
			begin
				sh[n-1] <= txd;
				n <= n + 1;
			end
		end
	end
	// ****
	// sender: start, data lsb first, optional ninth, stop
	// ****
	task automatic send(input logic [7:0] d, input logic b9, input logic stp);
		logic [10:0] f;
		f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++)
		begin
			@(negedge clk) rxd = f[i];
			do @(posedge clk); while (!bitTick);
		end
		// line idles high between frames
		@(negedge clk) rxd = 1'b1;
	endtask
endmodule

/* tb_usp_ctrl.sv */
// self-checking bench of the serial port control block
`timescale 1ns/1ns
`include "usp_cfg.svh"
module tb_usp_ctrl;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic bitTick = 1'b0;
	logic nine = 1'b0;
	logic [1:0] tickCnt = 2'h0;
	usp_pkg::usp_sfr_req_t sfrReq = '0;
	usp_pkg::usp_bit_req_t bitReq = '0;
	logic [7:0] sfrRdData;
	logic rxd;
	logic txd;
	logic irqReq;
	logic txFifoReady;
	logic [7:0] v;
	logic [7:0] d;
	logic [7:0] keep;
	logic [8:0] expQ[$];
	logic [9:0] tbl[8] = '{10'h101, 10'h141, 10'h140, 10'h1c0, 10'h1c1, 10'h341, 10'h3c1, 10'h3c3};
	int n_mismatch = 0;
	int check_count = 0;
	usp_ctrl dut_u (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .bitReq(bitReq), .sfrRdData(sfrRdData),
		.bitTick(bitTick), .rxd(rxd), .txd(txd), .irqReq(irqReq), .txFifoReady(txFifoReady));
	usp_remote rem_u (.clk(clk), .bitTick(bitTick), .nine(nine), .txd(txd), .rxd(rxd));
	always #50 clk = ~clk;
	// one bit time every four clocks keeps frames short
	always @(negedge clk)
	begin
		tickCnt <= tickCnt + 2'h1;
		bitTick <= (tickCnt == 2'h3);
	end
	// ****
	// tasks
	// ****
	task automatic chk(input logic [8:0] seen, input logic [8:0] want);
		check_count++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] val);
		@(negedge clk) sfrReq = {a, val, 1'b1, 1'b0};
		@(negedge clk) sfrReq.we = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] val);
		@(negedge clk) sfrReq = {a, 8'h00, 1'b0, 1'b1};
		@(negedge clk) sfrReq.re = 1'b0;
		val = sfrRdData;
	endtask
	task automatic bw(input logic [2:0] b, input logic val);
		@(negedge clk) bitReq = {`USP_BITADDR_HI, b, val, 1'b1};
		@(negedge clk) bitReq.bitWe = 1'b0;
	endtask
	task automatic txget(input logic [8:0] want);
		for (int i = 0; i < 800 && rem_u.q.size() == 0; i++)
			@(posedge clk);
		chk(rem_u.q.size() > 0 ? rem_u.q.pop_front() : 'x, want);
	endtask
	function automatic logic acc(input logic [7:0] c, input logic b9, input logic stp);
		return c[`USP_BIT_REN] && !(c[`USP_BIT_MDCHK] && !(c[`USP_BIT_FRAME] ? b9 : stp));
	endfunction
	task automatic rxc(input logic [7:0] c, input logic b9, input logic stp);
		logic a;
		a = acc(c, b9, stp);
		wr(`USP_CTL_ADDR, c);
		nine = c[`USP_BIT_FRAME];
		d = $urandom;
		rem_u.send(d, b9, stp);
		repeat (2) @(negedge clk);
		rd(`USP_CTL_ADDR, v);
		chk({irqReq, v[`USP_BIT_RXNINTH], v[`USP_BIT_RXDONE]}, {a, a & (nine ? b9 : stp), a});
		rd(`USP_BUF_ADDR, v);
		if (a)
			chk(v, d);
	endtask
	task automatic results;
		$display("mismatches %0d of %0d checks", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****
	// sequence
	// ****
	initial
	begin
		void'($urandom(32'h44443c08));
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		rd(`USP_CTL_ADDR, v);
		chk(v, `USP_CTL_RESET);
		rd(8'h9a, v);
		chk(v, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			nine = (k > 0);
			wr(`USP_CTL_ADDR, k == 2 ? 8'hc8 : (k == 1 ? 8'hc0 : 8'h40));
			d = $urandom;
			wr(`USP_BUF_ADDR, d);
			txget({k != 1, d});
			rd(`USP_CTL_ADDR, v);
			chk({irqReq, v[`USP_BIT_TXDONE]}, 2'h3);
		end
		bw(`USP_BIT_TXDONE, 1'b0);
		rd(`USP_CTL_ADDR, v);
		chk({irqReq, v}, {1'b0, 8'hc8});
		wr(`USP_CTL_ADDR, 8'h40);
		nine = 1'b0;
		// engine holds one byte, fifo the next eight; the tenth is dropped
		for (int k = 0; k < 10; k++)
		begin
			d = $urandom;
			if (k == 9)
				chk(txFifoReady, 1'b0);
			else
				expQ.push_back({1'b1, d});
			wr(`USP_BUF_ADDR, d);
		end
		while (expQ.size() > 0)
			txget(expQ.pop_front());
		foreach (tbl[i])
			rxc(tbl[i][9:2], tbl[i][1], tbl[i][0]);
		keep = d;
		wr(`USP_CTL_ADDR, 8'hd5);
		rem_u.send($urandom, 1'b0, 1'b1);
		repeat (2) @(negedge clk);
		rd(`USP_CTL_ADDR, v);
		chk(v, 8'hd5);
		rd(`USP_BUF_ADDR, v);
		chk(v, keep);
		// software clear lands on the stop-sample edge; the hardware set must win
		wr(`USP_CTL_ADDR, 8'h50);
		nine = 1'b0;
		d = $urandom;
		fork
			rem_u.send(d, 1'b0, 1'b1);
			begin
				wait (rxd == 1'b0);
				repeat (9) @(posedge clk iff bitTick);
				repeat (3) @(negedge clk);
				wr(`USP_CTL_ADDR, 8'h50);
			end
		join
		repeat (2) @(negedge clk);
		rd(`USP_CTL_ADDR, v);
		chk(v, 8'h55);
		rd(`USP_BUF_ADDR, v);
		chk(v, d);
		results;
	end
	// whole run needs about eleven hundred clocks; over twenty times that is ample
	initial
	begin
		#(30000 * 100);
		n_mismatch++;
		results;
	end
endmodule
